// ==== include/unbf_pkg.sv ====
// constants shared by the ninth-bit and completion-flag block
// assumes an 8-bit register port and one 125 MHz clock domain
package unbf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] FLAGS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] IRQ_CLR_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] IRQ_EN_OFS = 8'h10;

    ////////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int CTRL_NINE_BIT = 0;
    localparam int CTRL_TX_NINTH = 1;
    localparam int CTRL_SP_IE = 2;

    // flag register fields
    localparam int FLAG_RX_DONE = 0;
    localparam int FLAG_TX_DONE = 1;
    localparam int FLAG_RX_NINTH = 2;

    // sticky event bits for status, clear and enable
    localparam int EVT_TX = 0;
    localparam int EVT_RX = 1;
    localparam int EVT_OVR = 2;
    localparam int EVT_N = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic CTRL_NINE_BIT_RST = 1'b0;
    localparam logic CTRL_TX_NINTH_RST = 1'b0;
    localparam logic CTRL_SP_IE_RST = 1'b0;
    localparam logic RX_NINTH_RST = 1'b0;
    localparam logic [EVT_N-1:0] IRQ_EN_RST = 3'h0;
    localparam logic [DATA_W-1:0] RD_DATA_RST = 8'h00;
    localparam logic TX_IDLE_LEVEL = 1'b1;

    // serial frame format
    typedef enum logic {
        UNBF_MODE_8BIT = 1'b0,
        UNBF_MODE_9BIT = 1'b1
    } unbf_mode_t;

endpackage

// ==== rtl/unbf_sticky.sv ====
// one sticky flag: hardware sets it, a clear request drops it
// assumes set and clear are one-cycle pulses on the same clock
`timescale 1ns/1ps
module unbf_sticky (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic set_in,
    input wire logic clr_in,
    output logic flag_out
);

    logic flag_q;
    logic flag_d;

    ////////////////////////////////////////////////////////////////////////////
    // set beats clear so an event in the clearing cycle survives
    always_comb begin
        flag_d = flag_q;
        if (clr_in) begin
            flag_d = 1'b0;
        end
        if (set_in) begin
            flag_d = 1'b1;
        end
    end

    // only a reset or a clear request lowers the flag
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_out = flag_q;

endmodule

// ==== rtl/unbf_core.sv ====
// ninth-bit handling and completion flags of the serial port
// assumes the shifter and receiver pulse their frame points on mclk_in
//
// Summary of operation
// - nine-bit mode sends the software ninth bit as ninth frame bit
// - eight-bit mode ignores the ninth bit; software writes it anytime
// - mode 0 loads the received ninth bit with the stop bit level
// - mode 1 loads the received ninth bit with the ninth data bit
// - transmit done sets after bit eight, or at stop start in nine-bit
// - enabled, a set transmit-done flag requests the serial interrupt
// - receive done sets at stop sampling and requests the interrupt
// - done flags clear only by software writing zero, event bits by writing one, never by hardware
`timescale 1ns/1ps
module unbf_core (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [unbf_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [unbf_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [unbf_pkg::DATA_W-1:0] reg_rdata_out,
    // transmit shifter side
    input wire logic tx_bit8_done_in,
    input wire logic tx_stop_start_in,
    output logic tx_ninth_out,
    output logic nine_bit_mode_out,
    // receive side
    input wire logic rx_stop_sample_in,
    input wire logic rx_ninth_data_in,
    input wire logic rx_stop_level_in,
    // flag and interrupt outputs
    output logic tx_done_flag_out,
    output logic rx_done_flag_out,
    output logic rx_ninth_bit_out,
    output logic serial_port_irq_out,
    output logic irq_out
);

    import unbf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    // control state
    unbf_mode_t mode_q;
    logic tx_ninth_bit_q;
    logic sp_ie_q;

    // receive ninth bit and line output
    logic rx_ninth_bit_q;
    logic rx_ninth_bit_d;
    logic tx_ninth_q;
    logic tx_ninth_d;

    // completion flags
    logic tx_done_set;
    logic tx_done_clr;
    logic rx_done_set;
    logic rx_done_clr;
    logic tx_done_flag;
    logic rx_done_flag;

    // sticky events
    logic [EVT_N-1:0] evt_set;
    logic [EVT_N-1:0] evt_clr;
    logic [EVT_N-1:0] irq_stat;
    logic [EVT_N-1:0] irq_en_q;

    // interrupt lines
    logic sp_irq_q;
    logic sp_irq_d;
    logic irq_q;
    logic irq_d;

    // read data
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] rd_data_d;

    // decoded writes
    logic wr_ctrl;
    logic wr_flags;
    logic wr_irq_clr;
    logic wr_irq_en;

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // one strobe at one address selects a register
    function automatic logic reg_hit(
        input logic strobe,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        reg_hit = strobe && (addr == ofs);
    endfunction

    // writing zero to a flag bit clears it; a one leaves it alone
    function automatic logic zero_clears(
        input logic hit,
        input logic [DATA_W-1:0] data,
        input int pos
    );
        zero_clears = hit && !data[pos];
    endfunction

    // write strobes per register
    assign wr_ctrl = reg_hit(reg_wr_in, reg_addr_in, CTRL_OFS);
    assign wr_flags = reg_hit(reg_wr_in, reg_addr_in, FLAGS_OFS);
    assign wr_irq_clr = reg_hit(reg_wr_in, reg_addr_in, IRQ_CLR_OFS);
    assign wr_irq_en = reg_hit(reg_wr_in, reg_addr_in, IRQ_EN_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // control register

    // frame format selects which point sets transmit done and what loads the ninth bit
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            mode_q <= unbf_mode_t'(CTRL_NINE_BIT_RST);
        end else if (wr_ctrl) begin
            mode_q <= unbf_mode_t'(reg_wdata_in[CTRL_NINE_BIT]);
        end
    end

    // accepted in either mode, even mid-frame
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            tx_ninth_bit_q <= CTRL_TX_NINTH_RST;
        end else if (wr_ctrl) begin
            tx_ninth_bit_q <= reg_wdata_in[CTRL_TX_NINTH];
        end
    end

    // serial port interrupt enable
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            sp_ie_q <= CTRL_SP_IE_RST;
        end else if (wr_ctrl) begin
            sp_ie_q <= reg_wdata_in[CTRL_SP_IE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit ninth bit

    // eight-bit frames hold the line at stop level in that slot
    always_comb begin
        tx_ninth_d = TX_IDLE_LEVEL;
        if (mode_q == UNBF_MODE_9BIT) begin
            tx_ninth_d = tx_ninth_bit_q;
        end
    end

    // one cycle behind the control write; the shifter samples much later
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            tx_ninth_q <= TX_IDLE_LEVEL;
        end else begin
            tx_ninth_q <= tx_ninth_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive ninth bit

    // mode 0 keeps the stop level, mode 1 the ninth data bit
    always_comb begin
        rx_ninth_bit_d = rx_ninth_bit_q;
        if (rx_stop_sample_in) begin
            unique case (mode_q)
                UNBF_MODE_8BIT: begin
                    rx_ninth_bit_d = rx_stop_level_in;
                end
                UNBF_MODE_9BIT: begin
                    rx_ninth_bit_d = rx_ninth_data_in;
                end
            endcase
        end
    end

    // read-only; software cannot overwrite what the line delivered
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rx_ninth_bit_q <= RX_NINTH_RST;
        end else begin
            rx_ninth_bit_q <= rx_ninth_bit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // completion flags

    // the end-of-frame point depends on the frame format
    always_comb begin
        tx_done_set = tx_bit8_done_in;
        if (mode_q == UNBF_MODE_9BIT) begin
            tx_done_set = tx_stop_start_in;
        end
    end

    // receive done at the stop sampling instant of each byte
    assign rx_done_set = rx_stop_sample_in;

    // only a software zero clears; no frame point ever clears
    assign tx_done_clr = zero_clears(wr_flags, reg_wdata_in, FLAG_TX_DONE);
    assign rx_done_clr = zero_clears(wr_flags, reg_wdata_in, FLAG_RX_DONE);

    // transmit completion flag
    unbf_sticky u_tx_done (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(tx_done_set),
        .clr_in(tx_done_clr),
        .flag_out(tx_done_flag)
    );

    // receive completion flag
    unbf_sticky u_rx_done (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .set_in(rx_done_set),
        .clr_in(rx_done_clr),
        .flag_out(rx_done_flag)
    );

    ////////////////////////////////////////////////////////////////////////////
    // serial port interrupt request

    // level request, drops when both flags are gone or the enable is cleared
    always_comb begin
        sp_irq_d = sp_ie_q && (tx_done_flag || rx_done_flag);
    end

    // registered so the pin is glitch free; one cycle of latency
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            sp_irq_q <= 1'b0;
        end else begin
            sp_irq_q <= sp_irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky event status

    // a receive sample while receive done is still up loses a byte
    always_comb begin
        evt_set = '0;
        evt_set[EVT_TX] = tx_done_set;
        evt_set[EVT_RX] = rx_done_set;
        evt_set[EVT_OVR] = rx_done_set && rx_done_flag && !rx_done_clr;
    end

    // write-one-to-clear, bit for bit
    assign evt_clr = wr_irq_clr ? reg_wdata_in[EVT_N-1:0] : '0;

    // one sticky cell per event
    generate
        for (genvar i = 0; i < EVT_N; i++) begin : g_evt
            unbf_sticky u_evt (
                .mclk_in(mclk_in),
                .sys_rst_in(sys_rst_in),
                .set_in(evt_set[i]),
                .clr_in(evt_clr[i]),
                .flag_out(irq_stat[i])
            );
        end
    endgenerate

    // event enable mask
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            irq_en_q <= IRQ_EN_RST;
        end else if (wr_irq_en) begin
            irq_en_q <= reg_wdata_in[EVT_N-1:0];
        end
    end

    // summary interrupt over all enabled events
    always_comb begin
        irq_d = |(irq_stat & irq_en_q);
    end

    // level output, high while an enabled status bit stands
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    // unmapped and write-only addresses read as zero
    always_comb begin
        rd_data_d = RD_DATA_RST;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                CTRL_OFS: begin
                    rd_data_d[CTRL_NINE_BIT] = mode_q;
                    rd_data_d[CTRL_TX_NINTH] = tx_ninth_bit_q;
                    rd_data_d[CTRL_SP_IE] = sp_ie_q;
                end
                FLAGS_OFS: begin
                    rd_data_d[FLAG_RX_DONE] = rx_done_flag;
                    rd_data_d[FLAG_TX_DONE] = tx_done_flag;
                    rd_data_d[FLAG_RX_NINTH] = rx_ninth_bit_q;
                end
                IRQ_STAT_OFS: begin
                    rd_data_d[EVT_N-1:0] = irq_stat;
                end
                IRQ_EN_OFS: begin
                    rd_data_d[EVT_N-1:0] = irq_en_q;
                end
                default: begin
                    rd_data_d = RD_DATA_RST;
                end
            endcase
        end
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rd_data_q <= RD_DATA_RST;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops

    assign reg_rdata_out = rd_data_q;
    assign tx_ninth_out = tx_ninth_q;
    assign nine_bit_mode_out = mode_q;
    assign tx_done_flag_out = tx_done_flag;
    assign rx_done_flag_out = rx_done_flag;
    assign rx_ninth_bit_out = rx_ninth_bit_q;
    assign serial_port_irq_out = sp_irq_q;
    assign irq_out = irq_q;

endmodule

// ==== test/unbf_far_model.sv ====
// far side of the frame points: the shifter and the receiver
// assumes the bench commands one frame point at a time
`timescale 1ns/1ps
module unbf_far_model (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic go_in,
    input wire logic [1:0] kind_in,
    input wire logic ninth_in,
    input wire logic stop_in,
    output logic tx_bit8_done_out,
    output logic tx_stop_start_out,
    output logic rx_stop_sample_out,
    output logic rx_ninth_data_out,
    output logic rx_stop_level_out
);
    ////////////////////////////////////////////////////////////////////////////
    // one-cycle frame point pulses, a cycle after the command
    always_ff @(posedge mclk_in) begin
        tx_bit8_done_out <= go_in && kind_in == 2'h0;
        tx_stop_start_out <= go_in && kind_in == 2'h1;
        rx_stop_sample_out <= go_in && kind_in == 2'h2;
    end
    // data lines only mean something beside the sample pulse;
    // toggling elsewhere so a stale value cannot pass by luck
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rx_ninth_data_out <= 1'b0;
            rx_stop_level_out <= 1'b0;
        end else if (go_in && kind_in == 2'h2) begin
            rx_ninth_data_out <= ninth_in;
            rx_stop_level_out <= stop_in;
        end else begin
            rx_ninth_data_out <= ~rx_ninth_data_out;
            rx_stop_level_out <= ~rx_stop_level_out;
        end
    end
endmodule

// ==== test/unbf_core_chk.sv ====
// assertions on the ports of the ninth-bit and flag block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module unbf_core_chk (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [unbf_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [unbf_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic tx_bit8_done_in,
    input wire logic tx_stop_start_in,
    input wire logic rx_stop_sample_in,
    input wire logic rx_ninth_data_in,
    input wire logic rx_stop_level_in,
    input wire logic tx_ninth_out,
    input wire logic nine_bit_mode_out,
    input wire logic tx_done_flag_out,
    input wire logic rx_done_flag_out,
    input wire logic rx_ninth_bit_out,
    input wire logic serial_port_irq_out
);
    import unbf_pkg::*;
    logic ie_q;
    logic tn_q;
    logic ctl_wr;
    logic flg_wr;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////////////////
    // shadow of the enable bit, which is not a port of the block
    assign ctl_wr = reg_wr_in && reg_addr_in == CTRL_OFS;
    assign flg_wr = reg_wr_in && reg_addr_in == FLAGS_OFS;
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ie_q <= 1'b0;
        end else if (ctl_wr) begin
            ie_q <= reg_wdata_in[CTRL_SP_IE];
        end
    end
    // shadow of the software ninth bit; the output lags it by one register
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            tn_q <= CTRL_TX_NINTH_RST;
        end else if (ctl_wr) begin
            tn_q <= reg_wdata_in[CTRL_TX_NINTH];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_tx_point;
        nine_bit_mode_out ? tx_stop_start_in : tx_bit8_done_in;
    endsequence
    sequence s_any_req;
        ie_q && (tx_done_flag_out || rx_done_flag_out);
    endsequence
    a_tx_ninth_nine: assert property (nine_bit_mode_out |=>
        tx_ninth_out == $past(tn_q))
        else $error("ninth bit not sent in nine-bit mode");
    a_tx_ninth_eight: assert property (!nine_bit_mode_out |=> tx_ninth_out)
        else $error("ninth bit used in eight-bit mode");
    a_rx_ninth_stop: assert property (rx_stop_sample_in && !nine_bit_mode_out
        |=> rx_ninth_bit_out == $past(rx_stop_level_in))
        else $error("received ninth bit is not the stop level");
    a_rx_ninth_data: assert property (rx_stop_sample_in && nine_bit_mode_out
        |=> rx_ninth_bit_out == $past(rx_ninth_data_in))
        else $error("received ninth bit is not the ninth data bit");
    a_tx_done_set: assert property (s_tx_point |=> tx_done_flag_out)
        else $error("transmit done not set at frame point");
    a_tx_irq_req: assert property (ie_q && tx_done_flag_out |=> serial_port_irq_out)
        else $error("transmit done did not request interrupt");
    a_rx_done_set: assert property (rx_stop_sample_in |=> rx_done_flag_out)
        else $error("receive done not set at stop sample");
    a_rx_irq_req: assert property (ie_q && rx_done_flag_out |=> serial_port_irq_out)
        else $error("receive done did not request interrupt");
    a_tx_done_hold: assert property (tx_done_flag_out &&
        !(flg_wr && !reg_wdata_in[FLAG_TX_DONE]) |=> tx_done_flag_out)
        else $error("transmit done dropped without software");
    a_rx_done_clear: assert property (flg_wr && !reg_wdata_in[FLAG_RX_DONE] &&
        !rx_stop_sample_in |=> !rx_done_flag_out)
        else $error("receive done not cleared by zero write");
    a_irq_drop: assert property (!(ie_q && (tx_done_flag_out || rx_done_flag_out))
        |=> !serial_port_irq_out)
        else $error("serial request high without enabled flag");
    a_irq_follow: assert property (s_any_req |=> serial_port_irq_out)
        else $error("serial request low with enabled flag");
endmodule
bind unbf_core unbf_core_chk i_chk (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .tx_bit8_done_in(tx_bit8_done_in),
    .tx_stop_start_in(tx_stop_start_in),
    .rx_stop_sample_in(rx_stop_sample_in),
    .rx_ninth_data_in(rx_ninth_data_in),
    .rx_stop_level_in(rx_stop_level_in),
    .tx_ninth_out(tx_ninth_out),
    .nine_bit_mode_out(nine_bit_mode_out),
    .tx_done_flag_out(tx_done_flag_out),
    .rx_done_flag_out(rx_done_flag_out),
    .rx_ninth_bit_out(rx_ninth_bit_out),
    .serial_port_irq_out(serial_port_irq_out)
);

// ==== test/uart_ninth_bit_and_flags_tb.sv ====
// self-checking bench for the ninth-bit and flag block
// assumes the far model pulses frame points a cycle after command
`timescale 1ns/1ps
module uart_ninth_bit_and_flags_tb;
    import unbf_pkg::*;
    logic mclk_in, sys_rst_in, wr, rd, go, ninth, stop;
    logic [7:0] addr, wdata, rdata;
    logic [1:0] kind;
    logic b8, ss, smp, n9, sl, txn, nbm, txd, rxd, rxn, spi, irq;
    int fails, n_checks;
    unbf_far_model i_far (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .go_in(go),
        .kind_in(kind), .ninth_in(ninth), .stop_in(stop), .tx_bit8_done_out(b8),
        .tx_stop_start_out(ss), .rx_stop_sample_out(smp), .rx_ninth_data_out(n9),
        .rx_stop_level_out(sl));
    unbf_core i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .tx_bit8_done_in(b8), .tx_stop_start_in(ss), .tx_ninth_out(txn),
        .nine_bit_mode_out(nbm), .rx_stop_sample_in(smp), .rx_ninth_data_in(n9),
        .rx_stop_level_in(sl), .tx_done_flag_out(txd), .rx_done_flag_out(rxd),
        .rx_ninth_bit_out(rxn), .serial_port_irq_out(spi), .irq_out(irq));
    ////////////////////////////////////////////////////////////////////////////
    // clock and shared tasks; every task ends settled, 1 ns past an edge
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk_in);
        wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask
    // kind 0 bit eight sent, 1 stop start, 2 stop sample
    task automatic point(input logic [1:0] k, input logic n, input logic s);
        @(posedge mclk_in);
        go <= 1'b1;
        kind <= k;
        ninth <= n;
        stop <= s;
        @(posedge mclk_in);
        go <= 1'b0;
        tick(3);
    endtask
    task automatic report_and_stop;
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        n_checks = 0;
        {sys_rst_in, wr, rd, go, ninth, stop} = 6'h20;
        {addr, wdata, kind} = 18'h00000;
        tick(8);
        sys_rst_in <= 1'b0;
        rd_reg(CTRL_OFS, 8'h00, "ctrl reset");
        rd_reg(IRQ_EN_OFS, 8'h00, "enable reset");
        // eight-bit mode: ninth bit ignored, bit eight ends the frame
        wr_reg(CTRL_OFS, 8'h02);
        tick(1);
        chk(txn, 1'b1, "tx ninth 8bit");
        wr_reg(CTRL_OFS, 8'h00);
        tick(1);
        chk(txn, 1'b1, "tx ninth 8bit");
        point(2'h1, 1'b0, 1'b0);
        chk(txd, 1'b0, "tx done stop 8bit");
        point(2'h0, 1'b0, 1'b0);
        chk(txd, 1'b1, "tx done bit8");
        point(2'h2, 1'b0, 1'b1);
        chk(rxn, 1'b1, "rx ninth stop");
        point(2'h2, 1'b1, 1'b0);
        chk(rxn, 1'b0, "rx ninth stop");
        tick(20);
        rd_reg(FLAGS_OFS, 8'h03, "flags held");
        wr_reg(FLAGS_OFS, 8'h03);
        rd_reg(FLAGS_OFS, 8'h03, "flags one write");
        // request follows enable and both flags
        chk(spi, 1'b0, "irq disabled");
        wr_reg(CTRL_OFS, 8'h04);
        tick(1);
        chk(spi, 1'b1, "irq enabled");
        wr_reg(FLAGS_OFS, 8'h01);
        tick(1);
        chk({txd, spi}, 2'h1, "irq rx left");
        wr_reg(FLAGS_OFS, 8'h00);
        tick(1);
        chk({rxd, spi}, 2'h0, "irq both clear");
        point(2'h2, 1'b0, 1'b0);
        chk(spi, 1'b1, "irq rx done");
        wr_reg(FLAGS_OFS, 8'h00);
        // nine-bit mode: software ninth bit sent, stop start ends frame
        wr_reg(CTRL_OFS, 8'h03);
        tick(1);
        chk(txn, 1'b1, "tx ninth 9bit");
        wr_reg(CTRL_OFS, 8'h01);
        tick(1);
        chk(txn, 1'b0, "tx ninth 9bit");
        point(2'h0, 1'b0, 1'b0);
        chk(txd, 1'b0, "tx done bit8 9bit");
        point(2'h1, 1'b0, 1'b0);
        chk(txd, 1'b1, "tx done stop");
        point(2'h2, 1'b1, 1'b0);
        chk(rxn, 1'b1, "rx ninth data");
        point(2'h2, 1'b0, 1'b1);
        chk(rxn, 1'b0, "rx ninth data");
        ////////////////////////////////////////////////////////////////////////
        // sticky status, enable mask and clear; unmapped reads zero
        wr_reg(FLAGS_OFS, 8'h00);
        wr_reg(IRQ_CLR_OFS, 8'h07);
        wr_reg(IRQ_STAT_OFS, 8'hFF);
        rd_reg(IRQ_STAT_OFS, 8'h00, "status clear");
        point(2'h1, 1'b0, 1'b0);
        rd_reg(IRQ_STAT_OFS, 8'h01, "status tx");
        chk(irq, 1'b0, "irq masked");
        wr_reg(IRQ_EN_OFS, 8'h01);
        tick(1);
        chk(irq, 1'b1, "irq tx");
        wr_reg(IRQ_EN_OFS, 8'h00);
        tick(1);
        chk(irq, 1'b0, "irq masked");
        wr_reg(IRQ_EN_OFS, 8'h07);
        point(2'h2, 1'b0, 1'b0);
        rd_reg(IRQ_STAT_OFS, 8'h03, "status tx rx");
        // a second byte while receive done still stands is an overrun
        point(2'h2, 1'b0, 1'b0);
        rd_reg(IRQ_STAT_OFS, 8'h07, "status overrun");
        rd_reg(IRQ_EN_OFS, 8'h07, "enable");
        wr_reg(IRQ_CLR_OFS, 8'h07);
        tick(1);
        chk(irq, 1'b0, "irq cleared");
        rd_reg(IRQ_STAT_OFS, 8'h00, "status cleared");
        rd_reg(IRQ_CLR_OFS, 8'h00, "clear reads zero");
        rd_reg(8'h14, 8'h00, "unmapped");
        report_and_stop();
    end
endmodule
